/* design/ict_timing.sv */
`timescale 1ns/10ps
// What this block does
// - Every bus read, prefetch and write takes two clocks inside the total.
// - Long operand needs two transfers; adds two clocks to tail and total.
// - Test-and-set on memory takes 10 clocks, one prefetch, one write.
// - Shifts and plain rotates by immediate count take 6 clocks.
// - Register-count shifts follow the n/4 plus mod formula, at least 6.
// - Register-count rotate through extend: max(3+n+mod(n+1,2),6), n up to 63.
// - Immediate rotate through extend: max(2+n+mod(n,2),6), n up to 8.
// - Any memory shift or rotate takes 6 clocks, one prefetch, one write.
// - Immediate bit modify: memory 8 clocks two prefetch one write; register 6.
// - Bit test takes 4 clocks, no write, two prefetches if immediate.
// - Branch taken 8 clocks; untaken 4 byte or word, 6 long.
// - Loop mode taken decrement-and-branch takes 6 clocks, no bus cycles.
// - Interrupt processing takes 30 clocks, three reads, two prefetches, four writes.
// - External reset occupies 518 clocks with one prefetch.
// - Illegal and privilege-class exceptions take 25 clocks, 2/2/4 transfers.
// - Bounds check 8 clocks without exception, 42 clocks 2/2/6 with it.
// - Return from exception: 24 clocks four-word, 26 six-word frame.
// - Return from a bus-fault-on-write frame reruns that write cycle.
// - Address space code 7 marks the CPU space.
// - Only stack frame formats 0, 2 and C are built or accepted.
module ict_timing (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   // Operation request
   input  wire logic                  op_valid,
   output logic                       op_ready,
   input  wire ict_pkg::ict_op_type   op_code,
   input  wire ict_pkg::ict_size_type op_size,
   input  wire logic [5:0]            op_count,
   input  wire logic                  op_imm,
   input  wire logic                  op_taken,
   input  wire logic                  op_cond,
   input  wire logic                  op_loop,
   input  wire logic                  op_ex,
   input  wire logic [3:0]            op_frame,
   input  wire logic                  op_fault_write,
   // Bus sequencing
   output logic                       bus_start,
   output ict_pkg::ict_bus_type       bus_kind,
   output logic [2:0]                 address_space_code,
   output logic                       bus_active,
   // Status
   output logic                       busy,
   output logic                       op_done,
   output logic                       frame_reject,
   output logic [3:0]                 frame_fmt,
   output logic [9:0]                 total_clks
);
   import ict_pkg::*;

   ict_state_type   state_reg;
   logic [9:0]      cnt_reg;
   logic [3:0]      rd_reg;
   logic [3:0]      pf_reg;
   logic [3:0]      wr_reg;
   logic            cpu_reg;
   logic            start_reg;
   logic            active_reg;
   ict_bus_type     kind_reg;
   logic [2:0]      fc_reg;
   logic            done_reg;
   logic            reject_reg;
   logic [3:0]      fmt_reg;
   logic [9:0]      total_reg;

   logic [9:0]      t_clk;
   logic [3:0]      t_rd;
   logic [3:0]      t_pf;
   logic [3:0]      t_wr;
   logic            t_x;

   // Register-count shift formula pieces
   wire logic [9:0] sh_q     = {6'h00, op_count[5:2]};
   wire logic [9:0] sh_m     = {8'h00, op_count[1:0]};
   // Parity of n/4 + mod(n,4) is bit 2 xor bit 0, so no adder is needed for it
   wire logic [9:0] sh_par   = {9'h000, ~(op_count[2] ^ op_count[0])};
   wire logic [9:0] sh_raw   = ICT_T_3 + sh_q + sh_m + sh_par;
   wire logic [9:0] rx_n     = {4'h0, op_count};
   wire logic [9:0] rx_raw   = ICT_T_3 + rx_n + {9'h000, ~op_count[0]};
   // Immediate counts above the limit are clamped, not refused
   wire logic [5:0] ri_lim   = (op_count > ICT_ROTX_IMM_MAX) ? ICT_ROTX_IMM_MAX : op_count;
   wire logic [9:0] ri_raw   = ICT_T_2 + {4'h0, ri_lim} + {9'h000, ri_lim[0]};
   wire logic [9:0] sh_clk   = (sh_raw < ICT_T_6) ? ICT_T_6 : sh_raw;
   wire logic [9:0] rx_clk   = (rx_raw < ICT_T_6) ? ICT_T_6 : rx_raw;
   wire logic [9:0] ri_clk   = (ri_raw < ICT_T_6) ? ICT_T_6 : ri_raw;

   always_comb begin
      t_clk = ICT_T_2;
      t_rd  = ICT_N_0;
      t_pf  = ICT_N_1;
      t_wr  = ICT_N_0;
      t_x   = 1'b0;
      unique case (op_code)
         ICT_OP_UNARY_REG: begin
            t_clk = ICT_T_2;
         end
         ICT_OP_CLEAR_MEM: begin
            t_clk = ICT_T_4;
            t_wr  = ICT_N_1;
            t_x   = 1'b1;
         end
         ICT_OP_UNARY_MEM: begin
            t_clk = ICT_T_5;
            t_wr  = ICT_N_1;
            t_x   = 1'b1;
         end
         ICT_OP_TSET_REG: begin
            t_clk = ICT_T_6;
         end
         ICT_OP_TSET_MEM: begin
            t_clk = ICT_T_10;
            t_wr  = ICT_N_1;
         end
         ICT_OP_SHIFT_IMM: begin
            t_clk = ICT_T_6;
         end
         ICT_OP_SHIFT_REG: begin
            t_clk = sh_clk;
         end
         ICT_OP_ROTX_REG: begin
            t_clk = rx_clk;
         end
         ICT_OP_ROTX_IMM: begin
            t_clk = ri_clk;
         end
         ICT_OP_SHIFT_MEM: begin
            t_clk = ICT_T_6;
            t_wr  = ICT_N_1;
         end
         ICT_OP_BITMOD_MEM: begin
            t_clk = op_imm ? ICT_T_8 : ICT_T_8;
            t_pf  = op_imm ? ICT_N_2 : ICT_N_1;
            t_wr  = ICT_N_1;
         end
         ICT_OP_BITMOD_REG: begin
            t_clk = ICT_T_6;
            t_pf  = op_imm ? ICT_N_2 : ICT_N_1;
         end
         ICT_OP_BIT_TEST: begin
            t_clk = ICT_T_4;
            t_pf  = op_imm ? ICT_N_2 : ICT_N_1;
         end
         ICT_OP_BRANCH: begin
            if (op_taken) begin
               t_clk = ICT_T_8;
               t_pf  = ICT_N_2;
            end else if (op_size == ICT_SZ_LONG) begin
               t_clk = ICT_T_6;
               t_pf  = ICT_N_3;
            end else begin
               t_clk = ICT_T_4;
               t_pf  = (op_size == ICT_SZ_WORD) ? ICT_N_2 : ICT_N_1;
            end
         end
         ICT_OP_DEC_BRANCH: begin
            if (op_loop) begin
               t_clk = (op_taken || op_cond) ? ICT_T_6 : ICT_T_8;
               t_pf  = op_taken ? ICT_N_0 : ICT_N_1;
            end else begin
               t_clk = op_taken ? ICT_T_10 : (op_cond ? ICT_T_4 : ICT_T_6);
               t_pf  = ICT_N_2;
            end
         end
         ICT_OP_INTERRUPT: begin
            t_clk = ICT_T_30;
            t_rd  = ICT_N_3;
            t_pf  = ICT_N_2;
            t_wr  = ICT_N_4;
         end
         ICT_OP_DEV_RESET: begin
            t_clk = ICT_T_518;
         end
         ICT_OP_ILLEGAL: begin
            t_clk = ICT_T_25;
            t_rd  = ICT_N_2;
            t_pf  = ICT_N_2;
            t_wr  = ICT_N_4;
         end
         ICT_OP_BOUNDS: begin
            t_clk = op_ex ? ICT_T_42 : ICT_T_8;
            t_rd  = op_ex ? ICT_N_2 : ICT_N_0;
            t_pf  = op_ex ? ICT_N_2 : ICT_N_1;
            t_wr  = op_ex ? ICT_N_6 : ICT_N_0;
         end
         ICT_OP_RET_EXC: begin
            t_rd  = ICT_N_4;
            t_pf  = ICT_N_2;
            if (op_frame == ICT_FMT_2) begin
               t_clk = ICT_T_26;
            end else if (op_frame == ICT_FMT_C) begin
               t_clk = ICT_T_50;
               t_rd  = ICT_N_12;
               t_wr  = op_fault_write ? ICT_N_1 : ICT_N_0;
            end else begin
               t_clk = ICT_T_24;
            end
         end
         default: begin
            t_clk = ICT_T_2;
         end
      endcase
   end

   // Long operands double the write transfer
   // Only the clear and unary memory forms carry a sized operand
   wire logic       x_long  = t_x && (op_size == ICT_SZ_LONG);
   wire logic [9:0] a_clk   = x_long ? t_clk + ICT_T_BUS : t_clk;
   wire logic [3:0] a_wr    = x_long ? t_wr + ICT_N_1 : t_wr;

   // Only the three supported formats may be restored
   wire logic fmt_known = (op_frame == ICT_FMT_0) || (op_frame == ICT_FMT_2) ||
                          (op_frame == ICT_FMT_C);
   wire logic fmt_ok    = (op_code != ICT_OP_RET_EXC) || fmt_known;
   wire logic idle      = (state_reg == ICT_ST_IDLE);
   wire logic run       = (state_reg == ICT_ST_RUN);
   wire logic accept    = op_valid && idle && fmt_ok;
   // A refused restore leaves the core idle and only pulses the reject flag
   wire logic reject    = op_valid && idle && !fmt_ok;
   // The counter holds the clocks left after this one; zero marks the last busy cycle
   wire logic last      = run && (cnt_reg == 10'h000);

   // Bus scheduling: reads first, then prefetches, then writes, two clocks each
   wire logic [3:0] src_rd  = accept ? t_rd : rd_reg;
   wire logic [3:0] src_pf  = accept ? t_pf : pf_reg;
   wire logic [3:0] src_wr  = accept ? a_wr : wr_reg;
   // Only the first read of an interrupt is the acknowledge; later reads are stack data
   wire logic       src_cpu = accept ? (op_code == ICT_OP_INTERRUPT) : cpu_reg;
   // Nothing starts in the last busy cycle, or the transfer would spill past the total
   wire logic       slot    = accept || (run && !start_reg && !last);
   wire logic       any     = (src_rd != ICT_N_0) || (src_pf != ICT_N_0) || (src_wr != ICT_N_0);
   wire logic       go      = slot && any;
   wire ict_bus_type kind   = (src_rd != ICT_N_0) ? ICT_BUS_READ :
                              (src_pf != ICT_N_0) ? ICT_BUS_PREF : ICT_BUS_WRITE;
   wire logic       go_rd   = go && (kind == ICT_BUS_READ);
   wire logic       go_pf   = go && (kind == ICT_BUS_PREF);
   wire logic       go_wr   = go && (kind == ICT_BUS_WRITE);
   // The interrupt's first read is the acknowledge, run in CPU space
   wire logic [2:0] fc_next = (go_rd && src_cpu) ? ICT_FC_CPU :
                              go_pf ? ICT_FC_PROG : ICT_FC_DATA;

   // Exceptions record the frame they build; a restore records what it took back
   wire logic       exc_build = (op_code == ICT_OP_INTERRUPT) || (op_code == ICT_OP_ILLEGAL);
   wire logic       bnd_build = (op_code == ICT_OP_BOUNDS) && op_ex;
   wire logic [3:0] fmt_next  = !accept ? fmt_reg :
                                exc_build ? ICT_FMT_0 :
                                bnd_build ? ICT_FMT_2 :
                                (op_code == ICT_OP_RET_EXC) ? op_frame : fmt_reg;

   wire ict_state_type state_next = accept ? ICT_ST_RUN : (last ? ICT_ST_IDLE : state_reg);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= ICT_ST_IDLE;
         cnt_reg    <= 10'h000;
         rd_reg     <= ICT_N_0;
         pf_reg     <= ICT_N_0;
         wr_reg     <= ICT_N_0;
         cpu_reg    <= 1'b0;
         start_reg  <= 1'b0;
         active_reg <= 1'b0;
         kind_reg   <= ICT_BUS_NONE;
         fc_reg     <= ICT_FC_DATA;
         done_reg   <= 1'b0;
         reject_reg <= 1'b0;
         fmt_reg    <= ICT_FMT_0;
         total_reg  <= 10'h000;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= accept ? a_clk - 10'h001 : (run ? cnt_reg - 10'h001 : cnt_reg);
         rd_reg     <= src_rd - {3'h0, go_rd};
         pf_reg     <= src_pf - {3'h0, go_pf};
         wr_reg     <= src_wr - {3'h0, go_wr};
         cpu_reg    <= src_cpu && !go_rd;
         start_reg  <= go;
         active_reg <= go || start_reg;
         kind_reg   <= go ? kind : (start_reg ? kind_reg : ICT_BUS_NONE);
         fc_reg     <= go ? fc_next : fc_reg;
         done_reg   <= (run && cnt_reg == 10'h001) || (accept && a_clk == 10'h001);
         reject_reg <= reject;
         fmt_reg    <= fmt_next;
         total_reg  <= accept ? a_clk : total_reg;
      end
   end

   // Ready is the idle state itself, so nothing is taken while a count runs
   assign op_ready           = idle;
   assign bus_start          = start_reg;
   assign bus_kind           = kind_reg;
   assign address_space_code = fc_reg;
   assign bus_active         = active_reg;
   assign busy               = run;
   assign op_done            = done_reg;
   assign frame_reject       = reject_reg;
   assign frame_fmt          = fmt_reg;
   assign total_clks         = total_reg;

endmodule

/* design/ict_pkg.sv */
package ict_pkg;

   typedef enum logic [4:0] {
      ICT_OP_UNARY_REG  = 5'h00,
      ICT_OP_CLEAR_MEM  = 5'h01,
      ICT_OP_UNARY_MEM  = 5'h02,
      ICT_OP_TSET_REG   = 5'h03,
      ICT_OP_TSET_MEM   = 5'h04,
      ICT_OP_SHIFT_IMM  = 5'h05,
      ICT_OP_SHIFT_REG  = 5'h06,
      ICT_OP_ROTX_REG   = 5'h07,
      ICT_OP_ROTX_IMM   = 5'h08,
      ICT_OP_SHIFT_MEM  = 5'h09,
      ICT_OP_BITMOD_MEM = 5'h0A,
      ICT_OP_BITMOD_REG = 5'h0B,
      ICT_OP_BIT_TEST   = 5'h0C,
      ICT_OP_BRANCH     = 5'h0D,
      ICT_OP_DEC_BRANCH = 5'h0E,
      ICT_OP_INTERRUPT  = 5'h0F,
      ICT_OP_DEV_RESET  = 5'h10,
      ICT_OP_ILLEGAL    = 5'h11,
      ICT_OP_BOUNDS     = 5'h12,
      ICT_OP_RET_EXC    = 5'h13
   } ict_op_type;

   typedef enum logic [1:0] {
      ICT_SZ_BYTE = 2'h0,
      ICT_SZ_WORD = 2'h1,
      ICT_SZ_LONG = 2'h2
   } ict_size_type;

   typedef enum logic [1:0] {
      ICT_BUS_READ  = 2'h0,
      ICT_BUS_PREF  = 2'h1,
      ICT_BUS_WRITE = 2'h2,
      ICT_BUS_NONE  = 2'h3
   } ict_bus_type;

   typedef enum logic [1:0] {
      ICT_ST_IDLE = 2'b01,
      ICT_ST_RUN  = 2'b10
   } ict_state_type;

   localparam int ICT_CLK_W = 10;
   localparam int ICT_CNT_W = 4;

   // Clock totals per operation
   localparam logic [9:0] ICT_T_2   = 10'h002;
   localparam logic [9:0] ICT_T_3   = 10'h003;
   localparam logic [9:0] ICT_T_4   = 10'h004;
   localparam logic [9:0] ICT_T_5   = 10'h005;
   localparam logic [9:0] ICT_T_6   = 10'h006;
   localparam logic [9:0] ICT_T_8   = 10'h008;
   localparam logic [9:0] ICT_T_10  = 10'h00A;
   localparam logic [9:0] ICT_T_24  = 10'h018;
   localparam logic [9:0] ICT_T_25  = 10'h019;
   localparam logic [9:0] ICT_T_26  = 10'h01A;
   localparam logic [9:0] ICT_T_30  = 10'h01E;
   localparam logic [9:0] ICT_T_42  = 10'h02A;
   localparam logic [9:0] ICT_T_50  = 10'h032;
   localparam logic [9:0] ICT_T_518 = 10'h206;
   // Every bus transfer is two clocks; a long operand adds one transfer
   localparam logic [9:0] ICT_T_BUS = 10'h002;

   // Bus cycle counts
   localparam logic [3:0] ICT_N_0  = 4'h0;
   localparam logic [3:0] ICT_N_1  = 4'h1;
   localparam logic [3:0] ICT_N_2  = 4'h2;
   localparam logic [3:0] ICT_N_3  = 4'h3;
   localparam logic [3:0] ICT_N_4  = 4'h4;
   localparam logic [3:0] ICT_N_6  = 4'h6;
   localparam logic [3:0] ICT_N_12 = 4'hC;

   // Count limits for the rotate-through-extend forms
   localparam logic [5:0] ICT_ROTX_IMM_MAX = 6'h08;

   // Address space codes
   localparam logic [2:0] ICT_FC_CPU  = 3'h7;
   localparam logic [2:0] ICT_FC_DATA = 3'h5;
   localparam logic [2:0] ICT_FC_PROG = 3'h6;

   // Stack frame formats
   localparam logic [3:0] ICT_FMT_0 = 4'h0;
   localparam logic [3:0] ICT_FMT_2 = 4'h2;
   localparam logic [3:0] ICT_FMT_C = 4'hC;

endpackage

/* tb/ict_timing_properties.sv */
`timescale 1ns/10ps
module ict_timing_properties
   import ict_pkg::*;
(
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  arst_n,
   // Request
   input wire logic                  op_valid,
   input wire logic                  op_ready,
   input wire ict_pkg::ict_op_type   op_code,
   input wire logic                  op_taken,
   input wire logic                  op_loop,
   input wire logic [3:0]            op_frame,
   // Bus and status
   input wire logic                  bus_start,
   input wire ict_pkg::ict_bus_type  bus_kind,
   input wire logic [2:0]            address_space_code,
   input wire logic                  bus_active,
   input wire logic                  busy,
   input wire logic                  op_done,
   input wire logic                  frame_reject
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   wire fmt_ok = op_frame == ICT_FMT_0 || op_frame == ICT_FMT_2 || op_frame == ICT_FMT_C;
   wire take   = op_valid && op_ready && (op_code != ICT_OP_RET_EXC || fmt_ok);
   sequence s_xfer(ict_bus_type k);
      bus_start && bus_kind == k ##1 bus_active && !bus_start && bus_kind == k;
   endsequence
   property p_take_busy; take |=> busy && !op_ready; endproperty
   a_take_busy: assert property (p_take_busy) else $error("no busy after accept");
   property p_done_end; op_done |-> busy ##1 (!busy && op_ready); endproperty
   a_done_end: assert property (p_done_end) else $error("done not in last busy cycle");
   property p_xfer_two; bus_start |-> bus_active ##1 (bus_active && !bus_start && $stable(bus_kind)); endproperty
   a_xfer_two: assert property (p_xfer_two) else $error("transfer not two clocks");
   property p_unary; take && op_code == ICT_OP_UNARY_REG |=> s_xfer(ICT_BUS_PREF) ##0 op_done ##1 !busy; endproperty
   a_unary: assert property (p_unary) else $error("register unary timing");
   property p_tset_mem;
      take && op_code == ICT_OP_TSET_MEM |=> s_xfer(ICT_BUS_PREF) ##1 s_xfer(ICT_BUS_WRITE) ##6 op_done ##1 !busy;
   endproperty
   a_tset_mem: assert property (p_tset_mem) else $error("memory test-and-set timing");
   property p_shift_imm; take && op_code == ICT_OP_SHIFT_IMM |=> s_xfer(ICT_BUS_PREF) ##4 op_done; endproperty
   a_shift_imm: assert property (p_shift_imm) else $error("immediate shift timing");
   property p_loop_taken;
      take && op_code == ICT_OP_DEC_BRANCH && op_loop && op_taken
         |=> (busy && !bus_active) [*5] ##1 (op_done && !bus_active);
   endproperty
   a_loop_taken: assert property (p_loop_taken) else $error("loop branch used the bus");
   property p_int_cpu;
      take && op_code == ICT_OP_INTERRUPT
         |=> bus_start && bus_kind == ICT_BUS_READ && address_space_code == ICT_FC_CPU;
   endproperty
   a_int_cpu: assert property (p_int_cpu) else $error("acknowledge not in cpu space");
   property p_frame_bad;
      op_valid && op_ready && op_code == ICT_OP_RET_EXC && !fmt_ok |=> frame_reject && !busy;
   endproperty
   a_frame_bad: assert property (p_frame_bad) else $error("bad frame accepted");
endmodule

bind ict_timing ict_timing_properties ict_timing_properties_i (
   .core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
   .op_taken(op_taken), .op_loop(op_loop), .op_frame(op_frame), .bus_start(bus_start), .bus_kind(bus_kind),
   .address_space_code(address_space_code), .bus_active(bus_active), .busy(busy), .op_done(op_done),
   .frame_reject(frame_reject)
);

/* tb/ict_mem_model.sv */
`timescale 1ns/10ps
module ict_mem_model
   import ict_pkg::*;
(
   // Clock and reset
   input wire logic                  core_clk,
   input wire logic                  arst_n,
   // Transfers from the core
   input wire logic                  bus_start,
   input wire ict_pkg::ict_bus_type  bus_kind,
   // Running transfer counts
   output logic [15:0]               n_rd,
   output logic [15:0]               n_pf,
   output logic [15:0]               n_wr
);
   // Zero-wait memory: no ready line exists, so each access is over in its two clocks
   // No address reaches us; every access is taken as word aligned
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         n_rd <= 16'h0000;
         n_pf <= 16'h0000;
         n_wr <= 16'h0000;
      end else if (bus_start) begin
         case (bus_kind)
            ICT_BUS_READ:  n_rd <= n_rd + 16'h0001;
            ICT_BUS_PREF:  n_pf <= n_pf + 16'h0001;
            ICT_BUS_WRITE: n_wr <= n_wr + 16'h0001;
            default: ;
         endcase
      end
   end
endmodule

/* tb/instruction_cycle_timing_bench.sv */
`timescale 1ns/10ps
module instruction_cycle_timing_bench;
   import ict_pkg::*;
   logic         core_clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0;
   ict_op_type   op_code = ICT_OP_UNARY_REG;
   ict_size_type op_size = ICT_SZ_BYTE;
   logic [5:0]   op_count = 6'h00;
   logic         op_imm = 1'b0, op_taken = 1'b0, op_cond = 1'b0, op_loop = 1'b0, op_ex = 1'b0, op_fault_write = 1'b0;
   logic [3:0]   op_frame = 4'h0, frame_fmt, exp_fmt = 4'h0;
   logic         op_ready, bus_start, bus_active, busy, op_done, frame_reject;
   ict_bus_type  bus_kind;
   logic [2:0]   address_space_code;
   logic [9:0]   total_clks;
   logic [15:0]  n_rd, n_pf, n_wr;
   int           n_mismatch = 0, cmp_count = 0, cycles = 0, seed = 37228;

   ict_timing ict_timing_i (
      .core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
      .op_size(op_size), .op_count(op_count), .op_imm(op_imm), .op_taken(op_taken), .op_cond(op_cond),
      .op_loop(op_loop), .op_ex(op_ex), .op_frame(op_frame), .op_fault_write(op_fault_write),
      .bus_start(bus_start), .bus_kind(bus_kind), .address_space_code(address_space_code),
      .bus_active(bus_active), .busy(busy), .op_done(op_done), .frame_reject(frame_reject),
      .frame_fmt(frame_fmt), .total_clks(total_clks));
   ict_mem_model ict_mem_model_i (.core_clk(core_clk), .arst_n(arst_n), .bus_start(bus_start),
      .bus_kind(bus_kind), .n_rd(n_rd), .n_pf(n_pf), .n_wr(n_wr));

   always #2 core_clk = ~core_clk;

   task wrap_up;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Generous ceiling: the full run needs roughly eight thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s op %0d expected %h seen %h", what, op_code, exp, seen);
      end
   endtask

   // Packs clocks, reads, prefetches and writes of the staged request
   function logic [21:0] expect_op();
      int a, t;
      logic [3:0] r, p, w;
      r = 4'h0; p = 4'h1; w = 4'h0; t = 2;
      case (op_code)
         ICT_OP_CLEAR_MEM: begin t = 4; w = 4'h1; end
         ICT_OP_UNARY_MEM: begin t = 5; w = 4'h1; end
         ICT_OP_TSET_REG, ICT_OP_SHIFT_IMM: t = 6;
         ICT_OP_TSET_MEM, ICT_OP_SHIFT_MEM: begin t = (op_code == ICT_OP_TSET_MEM) ? 10 : 6; w = 4'h1; end
         ICT_OP_SHIFT_REG: begin a = op_count / 4 + op_count % 4; t = 3 + a + (a + 1) % 2; end
         ICT_OP_ROTX_REG: t = 3 + op_count + (op_count + 1) % 2;
         ICT_OP_ROTX_IMM: begin a = (op_count > 8) ? 8 : op_count; t = 2 + a + a % 2; end
         ICT_OP_BITMOD_MEM: begin t = 8; w = 4'h1; p = op_imm ? 4'h2 : 4'h1; end
         ICT_OP_BITMOD_REG: begin t = 6; p = op_imm ? 4'h2 : 4'h1; end
         ICT_OP_BIT_TEST: begin t = 4; p = op_imm ? 4'h2 : 4'h1; end
         ICT_OP_BRANCH: begin
            p = op_taken ? 4'h2 : {2'h0, op_size} + 4'h1;
            t = op_taken ? 8 : (op_size == ICT_SZ_LONG) ? 6 : 4;
         end
         ICT_OP_DEC_BRANCH: begin
            if (op_loop) begin
               p = op_taken ? 4'h0 : 4'h1;
               t = (op_taken || op_cond) ? 6 : 8;
            end else begin
               p = 4'h2;
               t = op_taken ? 10 : op_cond ? 4 : 6;
            end
         end
         ICT_OP_INTERRUPT: begin t = 30; r = 4'h3; p = 4'h2; w = 4'h4; end
         ICT_OP_DEV_RESET: t = 518;
         ICT_OP_ILLEGAL: begin t = 25; r = 4'h2; p = 4'h2; w = 4'h4; end
         ICT_OP_BOUNDS: begin
            t = op_ex ? 42 : 8;
            if (op_ex) begin r = 4'h2; p = 4'h2; w = 4'h6; end
         end
         ICT_OP_RET_EXC: begin
            r = 4'h4; p = 4'h2; t = (op_frame == 4'h0) ? 24 : 26;
            if (op_frame == 4'hC) begin t = 50; r = 4'hC; w = {3'h0, op_fault_write}; end
         end
         default: ;
      endcase
      if (op_code inside {ICT_OP_SHIFT_REG, ICT_OP_ROTX_REG, ICT_OP_ROTX_IMM} && t < 6) t = 6;
      if (op_size == ICT_SZ_LONG && op_code inside {ICT_OP_CLEAR_MEM, ICT_OP_UNARY_MEM}) begin
         t += 2;
         w += 4'h1;
      end
      return {t[9:0], r, p, w};
   endfunction

   task set_op(input ict_op_type c, input int j, input int cnt);
      op_code = c; op_size = ict_size_type'(j % 3); op_count = cnt[5:0];
      op_imm = j[0]; op_loop = j[0]; op_taken = j[1]; op_ex = j[1]; op_cond = j[2]; op_fault_write = j[2];
      op_frame = (j % 3 == 0) ? ICT_FMT_0 : (j % 3 == 1) ? ICT_FMT_2 : ICT_FMT_C;
   endtask

   // Called at a falling edge with the core idle; returns at the first idle falling edge after it
   task go;
      logic [21:0] e;
      logic [15:0] r0, p0, w0;
      int n;
      e = expect_op(); r0 = n_rd; p0 = n_pf; w0 = n_wr; n = 0;
      if (op_code == ICT_OP_INTERRUPT || op_code == ICT_OP_ILLEGAL) exp_fmt = ICT_FMT_0;
      if (op_code == ICT_OP_BOUNDS && op_ex) exp_fmt = ICT_FMT_2;
      if (op_code == ICT_OP_RET_EXC) exp_fmt = op_frame;
      op_valid = 1'b1;
      @(negedge core_clk);
      // A request held up while busy must be ignored
      op_code = ICT_OP_ILLEGAL;
      while (busy === 1'b1 && n < 600) begin
         if (n == 1) op_valid = 1'b0;
         n++;
         @(negedge core_clk);
      end
      check("busy cycles", n[15:0], {6'h00, e[21:12]});
      check("total clocks", {6'h00, total_clks}, {6'h00, e[21:12]});
      check("reads", n_rd - r0, {12'h000, e[11:8]});
      check("prefetches", n_pf - p0, {12'h000, e[7:4]});
      check("writes", n_wr - w0, {12'h000, e[3:0]});
      check("frame format", {12'h000, frame_fmt}, {12'h000, exp_fmt});
   endtask

   initial begin
      repeat (6) @(negedge core_clk);
      arst_n = 1'b1;
      check("idle after reset", {14'h0000, op_ready, busy}, 16'h0002);
      check("kind after reset", {14'h0000, bus_kind}, {14'h0000, ICT_BUS_NONE});
      check("space after reset", {13'h0000, address_space_code}, {13'h0000, ICT_FC_DATA});
      // Every operation with every variant; counts hit 0, 63 and the immediate limit of 8
      for (int c = 0; c < 20; c++) begin
         for (int j = 0; j < 8; j++) begin
            set_op(ict_op_type'(c), j, (c == 8) ? j + 1 : j * 9);
            go();
         end
      end
      repeat (40) begin
         set_op(ict_op_type'($unsigned($random(seed)) % 20), $unsigned($random(seed)) % 8,
                $unsigned($random(seed)) % 64);
         go();
      end
      for (int f = 1; f < 16; f += 6) begin
         op_code = ICT_OP_RET_EXC; op_frame = f[3:0]; op_valid = 1'b1;
         @(negedge core_clk);
         op_valid = 1'b0;
         check("frame refusal", {14'h0000, frame_reject, busy}, 16'h0002);
         @(negedge core_clk);
      end
      // Reset in the middle of a long operation
      set_op(ICT_OP_DEV_RESET, 0, 0);
      op_valid = 1'b1;
      @(negedge core_clk);
      op_valid = 1'b0;
      repeat (20) @(negedge core_clk);
      arst_n = 1'b0;
      exp_fmt = 4'h0;
      @(negedge core_clk);
      check("busy in reset", {15'h0000, busy}, 16'h0000);
      arst_n = 1'b1;
      set_op(ICT_OP_TSET_MEM, 0, 0);
      go();
      wrap_up();
   end
endmodule
